// *** shared/panel_seq_regs.vh ***
// Timing constants for the panel reset and power sequencer.
`ifndef PANEL_SEQ_REGS_VH
`define PANEL_SEQ_REGS_VH
`define CLK_PERIOD_NS     10
`define RST_REJECT_NS     5000
`define RST_ACCEPT_NS     15000
`define RST_REJECT_CYC    (`RST_REJECT_NS / `CLK_PERIOD_NS)
`define RST_ACCEPT_CYC    ((`RST_ACCEPT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DONE_SLPIN_MS     10
`define DONE_SLPOUT_MS    120
`define RELOAD_MS         10
`define PWRUP_MS          84
`define BLANK_FRAMES      2
`define FRAME_MS          16
`define MS_TO_CYC(ms)     ((ms) * 1000000 / `CLK_PERIOD_NS)
`define DONE_SLPIN_CYC    `MS_TO_CYC(`DONE_SLPIN_MS)
`define DONE_SLPOUT_CYC   `MS_TO_CYC(`DONE_SLPOUT_MS)
`define RELOAD_CYC        `MS_TO_CYC(`RELOAD_MS)
`define PWRUP_CYC         `MS_TO_CYC(`PWRUP_MS)
`define FRAME_CYC         `MS_TO_CYC(`FRAME_MS)
`endif

// *** rtl/panel_reset_seq.v ***
// Panel side reset filter, reload, sleep-out power-up and display-on blanking.
//
// Summary of operation
// - Reset pulses under 5 us are rejected.
// - Reset low over 15 us resets device.
// - Reset in sleep-in completes within 10 ms.
// - Reset in sleep-out completes within 120 ms.
// - Reload settings for 10 ms after the reset completion wait.
// - Sleep-out runs 84 ms internal power-up.
// - Display-on outputs two blank frames first.
`timescale 1ns/1ps
`default_nettype none
`include "panel_seq_regs.vh"

module panel_reset_seq #(
    parameter [31:0] ACCEPT_CYC  = `RST_ACCEPT_CYC,
    parameter [31:0] SLPIN_CYC   = `DONE_SLPIN_CYC,
    parameter [31:0] SLPOUT_CYC  = `DONE_SLPOUT_CYC,
    parameter [31:0] RELOAD_CYC  = `RELOAD_CYC,
    parameter [31:0] PWRUP_CYC   = `PWRUP_CYC,
    parameter [31:0] FRAME_CYC   = `FRAME_CYC,
    parameter [3:0]  BLANK_FRM   = `BLANK_FRAMES
) (
    input  wire       MCLK,          // 100 MHz clock
    input  wire       SRST,          // Synchronous reset, active high
    input  wire       PANEL_RESET_N, // Hardware reset pin, active low
    input  wire       CMD_SLPOUT,    // One-cycle sleep-out command
    input  wire       CMD_SLPIN,     // One-cycle sleep-in command
    input  wire       CMD_DISPON,    // One-cycle display-on command
    input  wire       CMD_DISPOFF,   // One-cycle display-off command
    output reg        READY,         // High when commands are accepted
    output reg        SLEEP_OUT,     // High while in sleep-out state
    output reg        IMAGE_ON,      // High when image is shown
    output reg        BLANKING,      // High while display outputs blanking
    output reg  [2:0] STATE          // Current sequencer state
);
    // State codes; the same codes are shown on STATE.
    localparam [2:0] S_RESET  = 3'h0;
    localparam [2:0] S_DONE   = 3'h1;
    localparam [2:0] S_RELOAD = 3'h2;
    localparam [2:0] S_IDLE   = 3'h3;
    localparam [2:0] S_PWRUP  = 3'h4;
    localparam [2:0] S_BLANK  = 3'h5;
    localparam [2:0] S_SHOW   = 3'h6;

    // Pin filter, interval timers and sequencer state.
    reg [2:0]  sync_q;
    reg        pin_q;
    reg [31:0] low_q;
    reg [31:0] tmr_q;
    reg [3:0]  frm_q;
    reg [2:0]  st_q;
    reg        slp_q;
    reg        disp_q;

    // Three flops bring the pin into this clock. The first may go
    // metastable, so only the second and third stages are compared.
    // The filtered level moves only when those two agree.
    always @(posedge MCLK) begin
        if (SRST) begin
            sync_q <= 3'h7;
            pin_q  <= 1'b1;
        end else begin
            sync_q <= {sync_q[1:0], PANEL_RESET_N};
            if (sync_q[1] == sync_q[2]) begin
                pin_q <= sync_q[2];
            end
        end
    end

    // The filtered pin is low.
    wire pin_low = !pin_q;

    // The low time has reached the accept count.
    wire long_low = (low_q >= ACCEPT_CYC - 32'h1);

    // A reset is taken only once the pin has stayed low for the
    // accept count, so short glitches never reach the state machine.
    wire rst_hit = pin_low && long_low;

    // The low-time counter clears whenever the pin is high and stops
    // once the accept count is reached, so it never wraps and one
    // long pulse cannot give a second reset.
    always @(posedge MCLK) begin
        if (SRST) begin
            low_q <= 32'h0;
        end else if (pin_q) begin
            low_q <= 32'h0;
        end else if (!rst_hit) begin
            low_q <= low_q + 32'h1;
        end
    end

    // Main sequencer. A taken reset overrides everything. The time to
    // complete it is chosen from the sleep state held at that moment,
    // and the reload period always follows the completion wait.
    always @(posedge MCLK) begin
        if (SRST) begin
            st_q   <= S_RESET;
            tmr_q  <= 32'h0;
            frm_q  <= 4'h0;
            slp_q  <= 1'b0;
            disp_q <= 1'b0;
        end else if (rst_hit) begin
            // Completion time depends on the sleep state at reset.
            if (st_q != S_RESET) begin
                tmr_q <= slp_q ? SLPOUT_CYC : SLPIN_CYC;
            end
            st_q   <= S_RESET;
            slp_q  <= slp_q;
            disp_q <= 1'b0;
        end else begin
            case (st_q)
            // Reset released: start the completion wait.
            S_RESET: begin
                st_q <= S_DONE;
            end
            // Completion wait, after which the device is in sleep-in.
            // The timer was loaded when the reset was taken.
            S_DONE: begin
                if (tmr_q != 32'h0) begin
                    tmr_q <= tmr_q - 32'h1;
                end else begin
                    slp_q <= 1'b0;
                    tmr_q <= RELOAD_CYC;
                    st_q  <= S_RELOAD;
                end
            end
            // Settings reload; no command is taken meanwhile.
            S_RELOAD: begin
                if (tmr_q != 32'h0) begin
                    tmr_q <= tmr_q - 32'h1;
                end else begin
                    st_q  <= S_IDLE;
                end
            end
            // Ready for commands in either sleep state.
            // Sleep-in here only clears the sleep flag.
            S_IDLE: begin
                if (CMD_SLPOUT && !slp_q) begin
                    tmr_q <= PWRUP_CYC;
                    st_q  <= S_PWRUP;
                end else if (CMD_SLPIN) begin
                    slp_q <= 1'b0;
                end else if (CMD_DISPON && slp_q) begin
                    tmr_q <= FRAME_CYC;
                    frm_q <= BLANK_FRM;
                    st_q  <= S_BLANK;
                end
            end
            // Internal power-up after sleep-out.
            // SLEEP_OUT rises only after the full count.
            S_PWRUP: begin
                if (tmr_q != 32'h0) begin
                    tmr_q <= tmr_q - 32'h1;
                end else begin
                    slp_q <= 1'b1;
                    st_q  <= S_IDLE;
                end
            end
            // Blank frames after display-on. The timer counts one frame
            // and the frame counter steps once per frame.
            // Display-off or sleep-in abandons the blank frames.
            S_BLANK: begin
                if (CMD_DISPOFF || CMD_SLPIN) begin
                    st_q <= S_IDLE;
                    slp_q <= CMD_SLPIN ? 1'b0 : slp_q;
                end else if (tmr_q > 32'h1) begin
                    tmr_q <= tmr_q - 32'h1;
                end else if (frm_q > 4'h1) begin
                    frm_q <= frm_q - 4'h1;
                    tmr_q <= FRAME_CYC;
                end else begin
                    disp_q <= 1'b1;
                    st_q   <= S_SHOW;
                end
            end
            // Image shown until display-off or sleep-in.
            S_SHOW: begin
                if (CMD_DISPOFF || CMD_SLPIN) begin
                    disp_q <= 1'b0;
                    slp_q  <= CMD_SLPIN ? 1'b0 : slp_q;
                    st_q   <= S_IDLE;
                end
            end
            // Unused codes fall back to reset.
            default: begin
                st_q <= S_RESET;
            end
            endcase
        end
    end

    // Every output is a registered copy of the sequencer state, so the
    // outputs lag the internal state by one clock and never glitch.
    // Blanking is shown whenever the image is not.
    always @(posedge MCLK) begin
        if (SRST) begin
            READY     <= 1'b0;
            SLEEP_OUT <= 1'b0;
            IMAGE_ON  <= 1'b0;
            BLANKING  <= 1'b1;
            STATE     <= S_RESET;
        end else begin
            READY     <= (st_q == S_IDLE) || (st_q == S_SHOW);
            SLEEP_OUT <= slp_q;
            IMAGE_ON  <= disp_q;
            BLANKING  <= !disp_q;
            STATE     <= st_q;
        end
    end
endmodule
`default_nettype wire

// *** sim/panel_seq_monitor.sv ***
// Checker for the panel sequencer outputs.
`timescale 1ns/1ps
`default_nettype none
module panel_seq_monitor #(
    parameter [31:0] RELOAD_CYC = 32'h1,
    parameter [31:0] PWRUP_CYC  = 32'h1,
    parameter [31:0] FRAME_CYC  = 32'h1
) (
    input wire logic       MCLK,      // Clock
    input wire logic       SRST,      // Reset
    input wire logic       READY,     // Ready
    input wire logic       SLEEP_OUT, // Awake
    input wire logic       IMAGE_ON,  // Image
    input wire logic       BLANKING,  // Blank
    input wire logic [2:0] STATE      // State
);
    logic [2:0]  st_q;
    logic [31:0] cnt_q;
    // Counts cycles in the current state, two behind the state's true age.
    always_ff @(posedge MCLK) begin
        st_q  <= STATE;
        cnt_q <= (SRST || STATE != st_q) ? 32'h0 : cnt_q + 32'h1;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);
    AST_SRST_IDLE: assert property (disable iff (1'b0)
        SRST |=> STATE == 3'h0 && !READY) else $error("reset not idle");
    AST_BLANK_INV: assert property (BLANKING == !IMAGE_ON)
        else $error("blanking wrong");
    AST_NOT_READY: assert property (STATE != 3'h3 && STATE != 3'h6 |-> !READY)
        else $error("ready too early");
    AST_RELOAD_LEN: assert property ($past(STATE) == 3'h2 && STATE == 3'h3
        |-> $past(cnt_q) + 2 >= RELOAD_CYC) else $error("reload short");
    AST_PWRUP_LEN: assert property ($rose(SLEEP_OUT) |-> $past(STATE) == 3'h4
        && $past(cnt_q) + 2 >= PWRUP_CYC) else $error("powerup short");
    AST_BLANK_LEN: assert property ($rose(IMAGE_ON) |-> $past(STATE) == 3'h5
        && $past(cnt_q) + 2 >= 2 * FRAME_CYC) else $error("blank short");
    AST_SHOW_RDY: assert property (IMAGE_ON |-> READY && SLEEP_OUT)
        else $error("image while asleep");
    AST_RST_CLR: assert property (STATE == 3'h0 |-> !IMAGE_ON && !READY)
        else $error("reset not quiet");
endmodule
bind panel_reset_seq panel_seq_monitor #(.RELOAD_CYC(RELOAD_CYC),
    .PWRUP_CYC(PWRUP_CYC), .FRAME_CYC(FRAME_CYC)) mon_u (.MCLK(MCLK),
    .SRST(SRST), .READY(READY), .SLEEP_OUT(SLEEP_OUT), .IMAGE_ON(IMAGE_ON),
    .BLANKING(BLANKING), .STATE(STATE));
`default_nettype wire

// *** sim/panel_host_model.sv ***
// Host model driving the panel reset pin and one-cycle commands.
`timescale 1ns/1ps
`default_nettype none
module panel_host_model (
    input  wire logic       mclk,  // Clock
    output var  logic       rst_n, // Reset pin
    output var  logic [3:0] cmd    // Slpout, slpin, dispon, dispoff
);
    initial begin
        rst_n = 1'b1;
        cmd   = 4'h0;
    end
    task automatic pin_low(input int n);
        @(negedge mclk) rst_n = 1'b0;
        repeat (n) @(negedge mclk);
        rst_n = 1'b1;
    endtask
    task automatic send(input int k);
        @(negedge mclk) cmd[k] = 1'b1;
        @(negedge mclk) cmd = 4'h0;
    endtask
endmodule
`default_nettype wire

// *** sim/panel_reset_seq_tb.sv ***
// Self-checking bench for the panel sequencer.
`timescale 1ns/1ps
`default_nettype none
module panel_reset_seq_tb;
    localparam int ACC = 20, SIN = 60, SOUT = 120, RLD = 50, PUP = 84, FRM = 16;
    logic mclk, srst, rdy, slp, img, blk;
    logic [2:0] st;
    wire logic rst_n;
    wire logic [3:0] cmd;
    int error_cnt = 0;
    int n_checks = 0;
    int n;
    panel_host_model host_u (.mclk(mclk), .rst_n(rst_n), .cmd(cmd));
    panel_reset_seq #(.ACCEPT_CYC(ACC), .SLPIN_CYC(SIN), .SLPOUT_CYC(SOUT),
        .RELOAD_CYC(RLD), .PWRUP_CYC(PUP), .FRAME_CYC(FRM)) dut_u (.MCLK(mclk),
        .SRST(srst), .PANEL_RESET_N(rst_n), .CMD_SLPOUT(cmd[0]),
        .CMD_SLPIN(cmd[1]), .CMD_DISPON(cmd[2]), .CMD_DISPOFF(cmd[3]),
        .READY(rdy), .SLEEP_OUT(slp), .IMAGE_ON(img), .BLANKING(blk), .STATE(st));
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // READY drops a couple of cycles after a command, so wait for that first.
    task automatic wrdy(output int c);
        c = 0;
        while (rdy === 1'b1 && c < 8) begin
            @(negedge mclk);
            c++;
        end
        c = 0;
        while (rdy !== 1'b1 && c < 2000) begin
            @(negedge mclk);
            c++;
        end
        if (rdy !== 1'b1) begin
            error_cnt++;
            $display("ERROR ready expected 1 seen %b", rdy);
        end
    endtask
    task automatic t_boot;
        wrdy(n);
        chk("boot", 1, n >= RLD && n < RLD + 10);
        $display("t_boot done");
    endtask
    task automatic t_short;
        host_u.pin_low(5);
        repeat (ACC + 10) @(negedge mclk);
        chk("short", 3, st);
        chk("short_rdy", 1, rdy);
        $display("t_short done");
    endtask
    task automatic t_off;
        host_u.send(3);
        repeat (2 * FRM) @(negedge mclk);
        host_u.send(1);
        repeat (8) @(negedge mclk);
        chk("off", 0, img | slp);
        $display("t_off done");
    endtask
    task automatic t_on;
        host_u.send(0);
        wrdy(n);
        chk("pwrup", 1, n >= PUP && n < PUP + 10);
        chk("awake", 1, slp);
        host_u.send(2);
        wrdy(n);
        chk("blank", 1, n >= 2 * FRM && n < 2 * FRM + 10);
        chk("image", 1, img);
        $display("t_on done");
    endtask
    task automatic t_rst(input int lo, hi);
        host_u.pin_low(ACC + 20);
        chk("held", 0, st);
        wrdy(n);
        chk("cmpl", 1, n >= lo + RLD && n < hi);
        chk("asleep", 0, slp);
        $display("t_rst done");
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        t_boot();
        t_short();
        t_on();
        t_rst(SOUT, SOUT + RLD + 12);
        t_rst(SIN, SIN + RLD + 12);
        t_on();
        t_off();
        summarize();
    end
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
